// ==== pse_defs.svh ====
// constants for the power status event register bank
// assumes inclusion by bare name from design and verification files
`ifndef PSE_DEFS_SVH
`define PSE_DEFS_SVH

// ----------------------------------------------------------------
// register indexes on the command port
// ----------------------------------------------------------------
`define PSE_IDX_OPERATION_SUMMARY_BIT_COND   4'h0
`define PSE_IDX_OPERATION_SUMMARY_BIT_EVENT  4'h1
`define PSE_IDX_OPERATION_SUMMARY_BIT_MASK   4'h2
`define PSE_IDX_OPERATION_SUMMARY_BIT_FALL   4'h3
`define PSE_IDX_OPERATION_SUMMARY_BIT_RISE   4'h4
`define PSE_IDX_QUESTIONABLE_SUMMARY_BIT_COND   4'h8
`define PSE_IDX_QUESTIONABLE_SUMMARY_BIT_EVENT  4'h9
`define PSE_IDX_QUESTIONABLE_SUMMARY_BIT_MASK   4'ha
`define PSE_IDX_QUESTIONABLE_SUMMARY_BIT_FALL   4'hb
`define PSE_IDX_QUESTIONABLE_SUMMARY_BIT_RISE   4'hc

// ----------------------------------------------------------------
// operation group bit positions
// ----------------------------------------------------------------
`define PSE_OPERATION_SUMMARY_BIT_CAL_BIT    0
`define PSE_OPERATION_SUMMARY_BIT_WTG_BIT    5
`define PSE_OPERATION_SUMMARY_BIT_CV_BIT     8
`define PSE_OPERATION_SUMMARY_BIT_CC_BIT     10
`define PSE_OPERATION_SUMMARY_BIT_STEP_BIT   12

// ----------------------------------------------------------------
// questionable group bit positions
// ----------------------------------------------------------------
`define PSE_QUESTIONABLE_SUMMARY_BIT_OV_BIT     0
`define PSE_QUESTIONABLE_SUMMARY_BIT_OC_BIT     1
`define PSE_QUESTIONABLE_SUMMARY_BIT_OT_BIT     4
`define PSE_QUESTIONABLE_SUMMARY_BIT_INH_BIT    9
`define PSE_QUESTIONABLE_SUMMARY_BIT_UNR_BIT    10

// ----------------------------------------------------------------
// masks, limits and reset values
// ----------------------------------------------------------------
`define PSE_OPERATION_SUMMARY_BIT_DEFINED    16'h1521
`define PSE_QUESTIONABLE_SUMMARY_BIT_DEFINED    16'h0613
`define PSE_OPERATION_SUMMARY_BIT_PRESET     16'd1313
`define PSE_QUESTIONABLE_SUMMARY_BIT_PRESET     16'd1555
`define PSE_MAX_VALUE       16'd32727
`define PSE_RESET_VALUE     16'h0000

// ----------------------------------------------------------------
// status byte positions of the summary bits
// ----------------------------------------------------------------
`define PSE_OPERATION_SUMMARY_BIT_SUM_POS    7
`define PSE_QUESTIONABLE_SUMMARY_BIT_SUM_POS    3

`endif

// ==== pse_pkg.sv ====
// types shared by the power status event register bank
// assumes pse_defs.svh is on the include path
`include "pse_defs.svh"

package pse_pkg;
	typedef logic [15:0] pse_word_t;
	typedef enum logic [3:0] {
		PSE_SEL_OPERATION_SUMMARY_BIT_COND  = 4'h0,
		PSE_SEL_OPERATION_SUMMARY_BIT_EVENT = 4'h1,
		PSE_SEL_OPERATION_SUMMARY_BIT_MASK  = 4'h2,
		PSE_SEL_OPERATION_SUMMARY_BIT_FALL  = 4'h3,
		PSE_SEL_OPERATION_SUMMARY_BIT_RISE  = 4'h4,
		PSE_SEL_QUESTIONABLE_SUMMARY_BIT_COND  = 4'h8,
		PSE_SEL_QUESTIONABLE_SUMMARY_BIT_EVENT = 4'h9,
		PSE_SEL_QUESTIONABLE_SUMMARY_BIT_MASK  = 4'ha,
		PSE_SEL_QUESTIONABLE_SUMMARY_BIT_FALL  = 4'hb,
		PSE_SEL_QUESTIONABLE_SUMMARY_BIT_RISE  = 4'hc
	} pse_sel_t;
endpackage

// ==== pse_status_bank.sv ====
// operation and questionable status groups of a programmable power module
// assumes a command decoder on clk_in drives the command port; status pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "pse_defs.svh"

// ----------------------------------------------------------------
// top level: command port, read mux and the two groups
// ----------------------------------------------------------------
module pse_status_bank (
	input  wire logic             clk_in,
	input  wire logic             sys_rst_in,
	input  wire logic             calibration_computing_in,
	input  wire logic             waiting_for_trigger_in,
	input  wire logic             constant_voltage_mode_in,
	input  wire logic             constant_current_mode_in,
	input  wire logic             list_step_complete_in,
	input  wire logic             overvoltage_tripped_in,
	input  wire logic             overcurrent_tripped_in,
	input  wire logic             overtemperature_in,
	input  wire logic             remote_inhibit_active_in,
	input  wire logic             output_unregulated_in,
	input  wire logic             cmd_write_in,
	input  wire logic             cmd_read_in,
	input  wire pse_pkg::pse_sel_t cmd_sel_in,
	input  wire logic [15:0]      cmd_wdata_in,
	input  wire logic             status_preset_command_in,
	output logic      [15:0]      read_data_out,
	output logic                  read_valid_out,
	output logic                  operation_summary_bit_out,
	output logic                  questionable_summary_bit_out
);
	import pse_pkg::*;

	// ----------------------------------------------------------------
	// status inputs gathered into group words
	// ----------------------------------------------------------------
	pse_word_t operation_summary_bit_raw;
	pse_word_t questionable_summary_bit_raw;

	always_comb begin
		operation_summary_bit_raw = `PSE_RESET_VALUE;
		operation_summary_bit_raw[`PSE_OPERATION_SUMMARY_BIT_CAL_BIT]  = calibration_computing_in;
		operation_summary_bit_raw[`PSE_OPERATION_SUMMARY_BIT_WTG_BIT]  = waiting_for_trigger_in;
		operation_summary_bit_raw[`PSE_OPERATION_SUMMARY_BIT_CV_BIT]   = constant_voltage_mode_in;
		operation_summary_bit_raw[`PSE_OPERATION_SUMMARY_BIT_CC_BIT]   = constant_current_mode_in;
		operation_summary_bit_raw[`PSE_OPERATION_SUMMARY_BIT_STEP_BIT] = list_step_complete_in;
	end

	always_comb begin
		questionable_summary_bit_raw = `PSE_RESET_VALUE;
		questionable_summary_bit_raw[`PSE_QUESTIONABLE_SUMMARY_BIT_OV_BIT]  = overvoltage_tripped_in;
		questionable_summary_bit_raw[`PSE_QUESTIONABLE_SUMMARY_BIT_OC_BIT]  = overcurrent_tripped_in;
		questionable_summary_bit_raw[`PSE_QUESTIONABLE_SUMMARY_BIT_OT_BIT]  = overtemperature_in;
		questionable_summary_bit_raw[`PSE_QUESTIONABLE_SUMMARY_BIT_INH_BIT] = remote_inhibit_active_in;
		questionable_summary_bit_raw[`PSE_QUESTIONABLE_SUMMARY_BIT_UNR_BIT] = output_unregulated_in;
	end

	// ----------------------------------------------------------------
	// the two groups
	// ----------------------------------------------------------------
	// group registers, read back through the mux below
	pse_word_t operation_summary_bit_cond;
	pse_word_t operation_summary_bit_event;
	pse_word_t operation_summary_bit_mask;
	pse_word_t operation_summary_bit_fall;
	pse_word_t operation_summary_bit_rise;
	pse_word_t questionable_summary_bit_cond;
	pse_word_t questionable_summary_bit_event;
	pse_word_t questionable_summary_bit_mask;
	pse_word_t questionable_summary_bit_fall;
	pse_word_t questionable_summary_bit_rise;
	logic      operation_summary_bit_sum;
	logic      questionable_summary_bit_sum;
	logic      wr;
	logic      rd;

	// a write and a read in one cycle: the write wins and the read is dropped
	assign wr = cmd_write_in;
	assign rd = cmd_read_in && !cmd_write_in;

	pse_group #(.DEFINED(`PSE_OPERATION_SUMMARY_BIT_DEFINED), .PRESET(`PSE_OPERATION_SUMMARY_BIT_PRESET)) u_operation_summary_bit (
		.clk_in      (clk_in),
		.sys_rst_in  (sys_rst_in),
		.raw_cond_in (operation_summary_bit_raw),
		.wr_mask_in  (wr && cmd_sel_in == PSE_SEL_OPERATION_SUMMARY_BIT_MASK),
		.wr_fall_in  (wr && cmd_sel_in == PSE_SEL_OPERATION_SUMMARY_BIT_FALL),
		.wr_rise_in  (wr && cmd_sel_in == PSE_SEL_OPERATION_SUMMARY_BIT_RISE),
		.rd_event_in (rd && cmd_sel_in == PSE_SEL_OPERATION_SUMMARY_BIT_EVENT),
		.preset_in   (status_preset_command_in),
		.wdata_in    (cmd_wdata_in),
		.cond_out    (operation_summary_bit_cond),
		.event_out   (operation_summary_bit_event),
		.mask_out    (operation_summary_bit_mask),
		.fall_out    (operation_summary_bit_fall),
		.rise_out    (operation_summary_bit_rise),
		.summary_out (operation_summary_bit_sum)
	);

	pse_group #(.DEFINED(`PSE_QUESTIONABLE_SUMMARY_BIT_DEFINED), .PRESET(`PSE_QUESTIONABLE_SUMMARY_BIT_PRESET)) u_questionable_summary_bit (
		.clk_in      (clk_in),
		.sys_rst_in  (sys_rst_in),
		.raw_cond_in (questionable_summary_bit_raw),
		.wr_mask_in  (wr && cmd_sel_in == PSE_SEL_QUESTIONABLE_SUMMARY_BIT_MASK),
		.wr_fall_in  (wr && cmd_sel_in == PSE_SEL_QUESTIONABLE_SUMMARY_BIT_FALL),
		.wr_rise_in  (wr && cmd_sel_in == PSE_SEL_QUESTIONABLE_SUMMARY_BIT_RISE),
		.rd_event_in (rd && cmd_sel_in == PSE_SEL_QUESTIONABLE_SUMMARY_BIT_EVENT),
		.preset_in   (status_preset_command_in),
		.wdata_in    (cmd_wdata_in),
		.cond_out    (questionable_summary_bit_cond),
		.event_out   (questionable_summary_bit_event),
		.mask_out    (questionable_summary_bit_mask),
		.fall_out    (questionable_summary_bit_fall),
		.rise_out    (questionable_summary_bit_rise),
		.summary_out (questionable_summary_bit_sum)
	);

	// ----------------------------------------------------------------
	// read port: data registered one cycle after the request
	// ----------------------------------------------------------------
	// registered answer; the data holds until the next read
	pse_word_t read_data_reg;
	logic      read_valid_reg;

	// read mux; an unknown index answers zero
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			read_data_reg  <= `PSE_RESET_VALUE;
			read_valid_reg <= 1'b0;
		end else begin
			read_valid_reg <= rd;
			if (rd) begin
				case (cmd_sel_in)
					PSE_SEL_OPERATION_SUMMARY_BIT_COND:  read_data_reg <= operation_summary_bit_cond;
					PSE_SEL_OPERATION_SUMMARY_BIT_EVENT: read_data_reg <= operation_summary_bit_event;
					PSE_SEL_OPERATION_SUMMARY_BIT_MASK:  read_data_reg <= operation_summary_bit_mask;
					PSE_SEL_OPERATION_SUMMARY_BIT_FALL:  read_data_reg <= operation_summary_bit_fall;
					PSE_SEL_OPERATION_SUMMARY_BIT_RISE:  read_data_reg <= operation_summary_bit_rise;
					PSE_SEL_QUESTIONABLE_SUMMARY_BIT_COND:  read_data_reg <= questionable_summary_bit_cond;
					PSE_SEL_QUESTIONABLE_SUMMARY_BIT_EVENT: read_data_reg <= questionable_summary_bit_event;
					PSE_SEL_QUESTIONABLE_SUMMARY_BIT_MASK:  read_data_reg <= questionable_summary_bit_mask;
					PSE_SEL_QUESTIONABLE_SUMMARY_BIT_FALL:  read_data_reg <= questionable_summary_bit_fall;
					PSE_SEL_QUESTIONABLE_SUMMARY_BIT_RISE:  read_data_reg <= questionable_summary_bit_rise;
					default:            read_data_reg <= `PSE_RESET_VALUE;
				endcase
			end
		end
	end

	// every top output comes straight from a flop
	assign read_data_out                = read_data_reg;
	assign read_valid_out               = read_valid_reg;
	assign operation_summary_bit_out    = operation_summary_bit_sum; // flop inside the group
	assign questionable_summary_bit_out = questionable_summary_bit_sum; // flop inside the group
endmodule

// ----------------------------------------------------------------
// one status group: condition, event, mask and two edge filters
// ----------------------------------------------------------------
module pse_group #(
	parameter logic [15:0] DEFINED = 16'h0000,
	parameter logic [15:0] PRESET  = 16'h0000
) (
	input  wire logic        clk_in,
	input  wire logic        sys_rst_in,
	input  wire logic [15:0] raw_cond_in,
	input  wire logic        wr_mask_in,
	input  wire logic        wr_fall_in,
	input  wire logic        wr_rise_in,
	input  wire logic        rd_event_in,
	input  wire logic        preset_in,
	input  wire logic [15:0] wdata_in,
	output logic      [15:0] cond_out,
	output logic      [15:0] event_out,
	output logic      [15:0] mask_out,
	output logic      [15:0] fall_out,
	output logic      [15:0] rise_out,
	output logic             summary_out
);
	import pse_pkg::*;

	// storage, next filter values and the combinational edge terms
	pse_word_t sync1_reg;
	pse_word_t cond_reg;
	pse_word_t prev_reg;
	pse_word_t event_reg;
	pse_word_t mask_reg;
	pse_word_t fall_reg;
	pse_word_t rise_reg;
	pse_word_t fall_next;
	pse_word_t rise_next;
	pse_word_t cond_live;
	pse_word_t edge_hits;
	pse_word_t filt_hits;
	logic      value_ok;
	logic      summary_reg;

	// two-flop synchroniser; nothing but the second stage reads the first
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			sync1_reg <= `PSE_RESET_VALUE;
			cond_reg  <= `PSE_RESET_VALUE;
			prev_reg  <= `PSE_RESET_VALUE;
		end else begin
			sync1_reg <= raw_cond_in;
			cond_reg  <= sync1_reg;
			prev_reg  <= cond_live;
		end
	end

	// unused positions forced to zero after the synchroniser, never between its stages
	assign cond_live = cond_reg & DEFINED;

	// out-of-range values are dropped so a stored filter never exceeds the limit
	assign value_ok = (wdata_in <= `PSE_MAX_VALUE);

	// filter values as they stand after this cycle's write or preset
	always_comb begin
		fall_next = fall_reg;
		rise_next = rise_reg;
		if (preset_in) begin
			fall_next = `PSE_RESET_VALUE;
			rise_next = PRESET;
		end else begin
			if (wr_fall_in && value_ok) begin
				fall_next = wdata_in;
			end
			if (wr_rise_in && value_ok) begin
				rise_next = wdata_in;
			end
		end
	end

	// edges judged against the updated filters; both zero blocks everything
	assign edge_hits = (cond_live & ~prev_reg & rise_next)
	                 | (~cond_live & prev_reg & fall_next);

	// a newly armed filter bit counts as an edge if the condition already sits there
	assign filt_hits = ((rise_next & ~rise_reg & cond_live)
	                 | (fall_next & ~fall_reg & ~cond_live)) & DEFINED;

	// filters and mask
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			mask_reg <= `PSE_RESET_VALUE;
			fall_reg <= `PSE_RESET_VALUE;
			rise_reg <= `PSE_RESET_VALUE;
		end else begin
			fall_reg <= fall_next;
			rise_reg <= rise_next;
			if (preset_in) begin
				mask_reg <= `PSE_RESET_VALUE;
			end else if (wr_mask_in && value_ok) begin
				mask_reg <= wdata_in;
			end
		end
	end

	// event latch: clear on read, but a same-cycle edge survives the clear
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			event_reg <= `PSE_RESET_VALUE;
		end else begin
			event_reg <= (rd_event_in ? `PSE_RESET_VALUE : event_reg)
			           | edge_hits | filt_hits;
		end
	end

	// summary lags the event latch by one cycle to keep the output a flop
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			summary_reg <= 1'b0;
		end else begin
			summary_reg <= |(event_reg & mask_reg);
		end
	end

	// outputs straight from the registers; condition already masked
	assign cond_out    = cond_live;
	assign event_out   = event_reg;
	assign mask_out    = mask_reg;
	assign fall_out    = fall_reg;
	assign rise_out    = rise_reg;
	assign summary_out = summary_reg;
endmodule

`default_nettype wire

// ==== pse_status_chk.sv ====
// checker for the power status event register bank, bound to its top module
// assumes pse_pkg and pse_defs.svh are compiled first; one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
`include "pse_defs.svh"

// ----------------------------------------------------------------
// port-level checker
// ----------------------------------------------------------------
module pse_status_chk (
	input wire logic              clk_in,
	input wire logic              sys_rst_in,
	input wire logic              cmd_write_in,
	input wire logic              cmd_read_in,
	input wire pse_pkg::pse_sel_t cmd_sel_in,
	input wire logic [15:0]       cmd_wdata_in,
	input wire logic              status_preset_command_in,
	input wire logic [15:0]       read_data_out,
	input wire logic              read_valid_out,
	input wire logic              operation_summary_bit_out,
	input wire logic              questionable_summary_bit_out
);
	import pse_pkg::*;
	default clocking dc @(posedge clk_in);
	endclocking
	default disable iff (sys_rst_in);

	// writable registers only; condition and event ignore writes
	logic rw_sel;
	assign rw_sel = cmd_sel_in inside {PSE_SEL_OPERATION_SUMMARY_BIT_MASK, PSE_SEL_OPERATION_SUMMARY_BIT_FALL, PSE_SEL_OPERATION_SUMMARY_BIT_RISE,
		PSE_SEL_QUESTIONABLE_SUMMARY_BIT_MASK, PSE_SEL_QUESTIONABLE_SUMMARY_BIT_FALL, PSE_SEL_QUESTIONABLE_SUMMARY_BIT_RISE};

	// write, idle cycle, read back of the same register
	sequence wr_rd(logic big);
		cmd_write_in && rw_sel && !status_preset_command_in &&
		((cmd_wdata_in > `PSE_MAX_VALUE) == big) ##1 !cmd_write_in && !status_preset_command_in
		##1 cmd_read_in && !cmd_write_in && !status_preset_command_in &&
		cmd_sel_in == $past(cmd_sel_in, 2);
	endsequence

	rd_valid_a: assert property (cmd_read_in && !cmd_write_in |=> read_valid_out)
		else $error("read not answered");
	no_valid_a: assert property (!(cmd_read_in && !cmd_write_in) |=> !read_valid_out)
		else $error("read valid without a read");
	data_hold_a: assert property (!read_valid_out && !$past(sys_rst_in)
		|-> $stable(read_data_out))
		else $error("read data moved without a read");
	operation_summary_bit_unused_a: assert property (read_valid_out &&
		$past(cmd_sel_in) inside {PSE_SEL_OPERATION_SUMMARY_BIT_COND, PSE_SEL_OPERATION_SUMMARY_BIT_EVENT}
		|-> (read_data_out & ~`PSE_OPERATION_SUMMARY_BIT_DEFINED) == 16'h0000)
		else $error("unused operation bit read as one");
	questionable_summary_bit_unused_a: assert property (read_valid_out &&
		$past(cmd_sel_in) inside {PSE_SEL_QUESTIONABLE_SUMMARY_BIT_COND, PSE_SEL_QUESTIONABLE_SUMMARY_BIT_EVENT}
		|-> (read_data_out & ~`PSE_QUESTIONABLE_SUMMARY_BIT_DEFINED) == 16'h0000)
		else $error("unused questionable bit read as one");
	rst_quiet_a: assert property (disable iff (1'b0) sys_rst_in |=> !read_valid_out &&
		read_data_out == 16'h0000 && !operation_summary_bit_out && !questionable_summary_bit_out)
		else $error("outputs not cleared by reset");
	preset_sum_a: assert property (status_preset_command_in |=> ##1
		!operation_summary_bit_out && !questionable_summary_bit_out)
		else $error("summary set after masks were cleared");
	wr_back_a: assert property (wr_rd(1'b0) |=> read_data_out == $past(cmd_wdata_in, 3))
		else $error("written value not read back");
	big_refuse_a: assert property (wr_rd(1'b1) |=> read_data_out != $past(cmd_wdata_in, 3))
		else $error("value above limit was stored");

	// main scenarios reached
	cover property (read_valid_out && read_data_out != 16'h0000);
	cover property ($rose(operation_summary_bit_out));
	cover property ($rose(questionable_summary_bit_out));
	cover property (status_preset_command_in);
endmodule

bind pse_status_bank pse_status_chk i_pse_status_chk (
	.clk_in                       (clk_in),
	.sys_rst_in                   (sys_rst_in),
	.cmd_write_in                 (cmd_write_in),
	.cmd_read_in                  (cmd_read_in),
	.cmd_sel_in                   (cmd_sel_in),
	.cmd_wdata_in                 (cmd_wdata_in),
	.status_preset_command_in     (status_preset_command_in),
	.read_data_out                (read_data_out),
	.read_valid_out               (read_valid_out),
	.operation_summary_bit_out    (operation_summary_bit_out),
	.questionable_summary_bit_out (questionable_summary_bit_out)
);
`default_nettype wire

// ==== tb.sv ====
// self-checking testbench for the power status event register bank
// assumes pse_pkg, pse_status_bank and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "pse_defs.svh"

module tb;
	import pse_pkg::*;
	logic        clk_in, sys_rst_in, cmd_write, cmd_read, preset, rvalid, osum, qsum;
	pse_sel_t    cmd_sel;
	logic [15:0] cmd_wdata, rdata, v, c, r, f, df, old;
	logic [4:0]  pin [2];
	int          error_cnt, comparisons;

	// ----------------------------------------------------------------
	// design and clock
	// ----------------------------------------------------------------
	pse_status_bank i_pse_status_bank (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.calibration_computing_in(pin[0][0]), .waiting_for_trigger_in(pin[0][1]),
		.constant_voltage_mode_in(pin[0][2]), .constant_current_mode_in(pin[0][3]),
		.list_step_complete_in(pin[0][4]), .overvoltage_tripped_in(pin[1][0]),
		.overcurrent_tripped_in(pin[1][1]), .overtemperature_in(pin[1][2]),
		.remote_inhibit_active_in(pin[1][3]), .output_unregulated_in(pin[1][4]),
		.cmd_write_in(cmd_write), .cmd_read_in(cmd_read), .cmd_sel_in(cmd_sel),
		.cmd_wdata_in(cmd_wdata), .status_preset_command_in(preset), .read_data_out(rdata),
		.read_valid_out(rvalid), .operation_summary_bit_out(osum),
		.questionable_summary_bit_out(qsum));

	// 20 MHz
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end

	// ----------------------------------------------------------------
	// expectations and bus tasks
	// ----------------------------------------------------------------
	// pin vector to condition word of group g
	function automatic logic [15:0] cond_of(int g, logic [4:0] p);
		return g == 0 ? {3'h0, p[4], 1'h0, p[3], 1'h0, p[2], 2'h0, p[1], 4'h0, p[0]}
			: {5'h0, p[4], p[3], 4'h0, p[2], 2'h0, p[1], p[0]};
	endfunction
	function automatic logic [15:0] edg(logic [15:0] a, b, rf, ff);
		return (~a & b & rf) | (a & ~b & ff);
	endfunction
	function automatic pse_sel_t sl(int g, int o);
		return pse_sel_t'(4'(g * 8 + o));
	endfunction
	// inputs always move 1 ns after the edge, never on it
	task automatic step(int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task automatic chk(logic [15:0] got, exp, string m);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask
	// idle cycle after the pulse so back-to-back calls never retoggle in one step
	task automatic wr(pse_sel_t s, logic [15:0] d);
		cmd_sel = s;
		cmd_wdata = d;
		cmd_write = 1'b1;
		step(1);
		cmd_write = 1'b0;
		step(1);
	endtask
	task automatic rc(pse_sel_t s, logic [15:0] exp, bit cmp);
		int n;
		cmd_sel = s;
		cmd_read = 1'b1;
		step(1);
		cmd_read = 1'b0;
		n = 0;
		while (rvalid !== 1'b1 && n < 4) begin
			step(1);
			n++;
		end
		if (n == 4) begin
			error_cnt++;
			close_out();
		end else begin
			v = rdata;
			step(1);
			if (cmp)
				chk(v, exp, s.name());
		end
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{sys_rst_in, cmd_write, cmd_read, preset} = 4'h8;
		cmd_sel = PSE_SEL_OPERATION_SUMMARY_BIT_COND;
		{cmd_wdata, pin[0], pin[1]} = '0;
		{error_cnt, comparisons} = '0;
		void'($urandom(64));
		step(10);
		sys_rst_in = 1'b0;
		// reset value, random write, refused write one above the limit
		for (int g = 0; g < 2; g++) for (int o = 2; o < 5; o++) begin
			rc(sl(g, o), 16'h0000, 1);
			r = 16'($urandom_range(16'h7fd7, 0));
			wr(sl(g, o), r);
			rc(sl(g, o), r, 1);
			wr(sl(g, o), 16'h7fd8);
			rc(sl(g, o), r, 1);
			wr(sl(g, o), 16'h0000);
		end
		rc(sl(0, 5), 16'h0000, 1);
		$display("test registers done");
		// first pass all filters on, second all off, then random filters and pins
		for (int it = 0; it < 10; it++) for (int g = 0; g < 2; g++) begin
			df = g ? 16'h0613 : 16'h1521;
			r = it == 0 ? df : it == 1 ? 16'h0000 : 16'($urandom) & df;
			f = it == 0 ? df : it == 1 ? 16'h0000 : 16'($urandom) & df;
			wr(sl(g, 4), r);
			wr(sl(g, 3), f);
			rc(sl(g, 1), 16'h0000, 0);
			old = cond_of(g, pin[g]);
			pin[g] = it < 2 ? ~pin[g] : 5'($urandom);
			step(4);
			rc(sl(g, 0), cond_of(g, pin[g]), 1);
			rc(sl(g, 1), edg(old, cond_of(g, pin[g]), r, f), 1);
			rc(sl(g, 1), 16'h0000, 1);
		end
		$display("test edges done");
		// arming a filter over a standing level, with the summary enabled
		for (int g = 0; g < 2; g++) begin
			df = g ? 16'h0613 : 16'h1521;
			wr(sl(g, 4), 16'h0000);
			wr(sl(g, 3), 16'h0000);
			wr(sl(g, 2), df);
			pin[g] = 5'($urandom) | 5'h01;
			step(4);
			rc(sl(g, 1), 16'h0000, 0);
			c = cond_of(g, pin[g]);
			wr(sl(g, 4), df);
			step(2);
			chk({15'h0, g ? qsum : osum}, 16'h0001, "summary set");
			rc(sl(g, 1), c, 1);
			step(2);
			chk({15'h0, g ? qsum : osum}, 16'h0000, "summary clear");
			wr(sl(g, 3), df);
			rc(sl(g, 1), ~c & df, 1);
		end
		$display("test arming done");
		// a pin edge latched in the very cycle of an event read: the read sees the old value
		for (int g = 0; g < 2; g++) begin
			df = g ? 16'h0613 : 16'h1521;
			pin[g] = ~pin[g];
			step(2);
			rc(sl(g, 1), 16'h0000, 1);
			rc(sl(g, 1), df, 1);
		end
		$display("test read collision done");
		preset = 1'b1;
		step(1);
		preset = 1'b0;
		step(1);
		for (int g = 0; g < 2; g++) begin
			rc(sl(g, 4), g ? 16'h0613 : 16'h0521, 1);
			rc(sl(g, 3), 16'h0000, 1);
			rc(sl(g, 2), 16'h0000, 1);
		end
		$display("test preset done");
		close_out();
	end
endmodule
`default_nettype wire
